// [hdl/sar_ctl_pkg.sv]
// constants and types shared by the converter control block
package sar_ctl_pkg;
    localparam int unsigned CLK_MHZ = 200;
    localparam int unsigned RES_BITS = 12;
    // nanosecond figures
    localparam int unsigned CONVERT_START_N_TIME_NS = 12000;
    localparam int unsigned DONE_TO_READY_NS = 90;
    localparam int unsigned FIRST_EDGE_NS = 2000;
    localparam int unsigned SCLK_HALF_NS = 355;
    localparam int unsigned UPDATE_LEAD_NS = 50;
    // cycle counts derived from the rate
    localparam int unsigned CONVERT_START_N_CYC = CONVERT_START_N_TIME_NS * CLK_MHZ / 1000;
    localparam int unsigned READY_CYC = DONE_TO_READY_NS * CLK_MHZ / 1000;
    localparam int unsigned FIRST_CYC = FIRST_EDGE_NS * CLK_MHZ / 1000;
    localparam int unsigned HALF_CYC = SCLK_HALF_NS * CLK_MHZ / 1000;
    localparam int unsigned LEAD_CYC = UPDATE_LEAD_NS * CLK_MHZ / 1000;
    localparam int unsigned FIFO_DEPTH = 8;
    localparam logic [11:0] CODE_RESET = 12'h000;
    typedef enum logic [1:0] {IDLE, CONVERT, SETTLE} convert_start_n_state_t;
endpackage

// [hdl/result_fifo.sv]
// small first-in first-out buffer with valid/ready on both sides
`default_nettype none
module result_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [AW:0] wr;
        logic [AW:0] rd;
    } fifo_state_t;
    fifo_state_t st_r, st_nxt;
    logic [WIDTH-1:0] mem [DEPTH];
    logic full, empty;

    // pointer carry bit separates full from empty
    assign empty = st_r.wr == st_r.rd;
    assign full = (st_r.wr[AW-1:0] == st_r.rd[AW-1:0]) && (st_r.wr[AW] != st_r.rd[AW]);
    assign inReady = !full;
    assign outValid = !empty;
    assign outData = mem[st_r.rd[AW-1:0]];

    always_comb begin
        st_nxt = st_r;
        if (inValid && !full) begin
            st_nxt.wr = st_r.wr + 1'b1;
        end
        if (outReady && !empty) begin
            st_nxt.rd = st_r.rd + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
        if (inValid && !full) begin
            mem[st_r.wr[AW-1:0]] <= inData;
        end
    end
endmodule
`default_nettype wire

// [hdl/sar_convert_start_n_serial.sv]
// conversion timing, result transfer and serial readout of a 12-bit sampling converter
`default_nettype none
module sar_convert_start_n_serial
    import sar_ctl_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic convertStart_n,
    input wire logic chipSelect_n,
    input wire logic clockSourceSelect,
    input wire logic [11:0] sampleCode,
    input wire logic sampleValid,
    output logic sampleReady,
    output logic serialBitClockOut,
    output logic serialBitClockOe,
    input wire logic serialBitClockIn,
    output logic serialData,
    output logic serialDataOe,
    output logic busy_n,
    output logic busyOe,
    output logic sampleHold
);
    typedef struct packed {
        logic [1:0] convSync;
        logic [1:0] csSync;
        logic [1:0] selSync;
        logic [1:0] sclkSync;
        logic convPrev;
        logic sclkPrev;
        convert_start_n_state_t state;
        logic [15:0] timer;
        logic [11:0] work;
        logic [11:0] shifter;
        logic [4:0] bitCnt;
        logic [9:0] sclkTimer;
        logic sclkLevel;
        logic dataBit;
        logic txActive;
        logic blocked;
        logic busyLow;
    } ctl_state_t;
    ctl_state_t st_r, st_nxt;
    logic fifoValid;
    logic [11:0] fifoData;
    logic fifoPop;
    logic convFall;
    logic extMode;
    logic extRise;
    logic extFall;

    // every output enable follows the synchronised chip select the same way
    function automatic logic pin_enable(input logic deselected);
        return !deselected;
    endfunction

    // a host clock counts as active only while high and gated in by chip select
    function automatic logic clock_active(input logic sclkHigh, input logic deselected);
        return sclkHigh && !deselected;
    endfunction

    // hazards worth knowing before touching the timing below:
    // the convert pin is only watched in idle, so a second fall mid-conversion is lost
    // the update of the shifter is the one moment a host clock can corrupt a result;
    // rather than shift garbage, the new result is dropped and the old word kept
    // the internal frame may outlive the conversion timer, so settle waits for it

    // the result queue decouples the analog core from the conversion timing
    result_fifo #(.WIDTH(RES_BITS), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(clk),
        .rst_b(rst_b),
        .inValid(sampleValid),
        .inReady(sampleReady),
        .inData(sampleCode),
        .outValid(fifoValid),
        .outReady(fifoPop),
        .outData(fifoData)
    );

    // edges are taken only from the second synchroniser stage
    assign convFall = st_r.convPrev && !st_r.convSync[1];
    assign extMode = st_r.selSync[1];
    assign extRise = !st_r.sclkPrev && st_r.sclkSync[1] && !st_r.csSync[1];
    assign extFall = st_r.sclkPrev && !st_r.sclkSync[1] && !st_r.csSync[1];
    // one code taken per conversion, at its start
    assign fifoPop = (st_r.state == IDLE) && convFall;

    always_comb begin
        st_nxt = st_r;
        st_nxt.convSync = {st_r.convSync[0], convertStart_n};
        st_nxt.csSync = {st_r.csSync[0], chipSelect_n};
        st_nxt.selSync = {st_r.selSync[0], clockSourceSelect};
        st_nxt.sclkSync = {st_r.sclkSync[0], serialBitClockIn};
        st_nxt.convPrev = st_r.convSync[1];
        st_nxt.sclkPrev = st_r.sclkSync[1];
        case (st_r.state)
            IDLE: begin
                // chip select plays no part here
                if (convFall) begin
                    st_nxt.state = CONVERT;
                    st_nxt.timer = 16'(CONVERT_START_N_CYC);
                    st_nxt.busyLow = 1'b1;
                    st_nxt.blocked = 1'b0;
                    // a missing code converts as zero
                    st_nxt.work = fifoValid ? fifoData : CODE_RESET;
                    if (!extMode) begin
                        st_nxt.txActive = 1'b1;
                        st_nxt.bitCnt = 5'd0;
                        st_nxt.sclkTimer = 10'(FIRST_CYC);
                        st_nxt.sclkLevel = 1'b0;
                        st_nxt.dataBit = st_r.shifter[11];
                    end
                end
            end
            CONVERT: begin
                // convert start is not looked at in this state
                st_nxt.timer = st_r.timer - 16'd1;
                // host clock active near the update spoils it
                if (extMode && st_r.timer <= 16'(LEAD_CYC)
                        && clock_active(st_r.sclkSync[1], st_r.csSync[1])) begin
                    st_nxt.blocked = 1'b1;
                end
                if (st_r.timer == 16'd1) begin
                    st_nxt.state = SETTLE;
                    st_nxt.timer = 16'(READY_CYC);
                end
            end
            SETTLE: begin
                st_nxt.timer = st_r.timer - 16'd1;
                // the update lands at the end of settle, so a host clock here spoils it too
                if (extMode && clock_active(st_r.sclkSync[1], st_r.csSync[1])) begin
                    st_nxt.blocked = 1'b1;
                end
                if (st_r.timer == 16'd1 && !st_r.txActive) begin
                    // copy on the same edge that busy returns high
                    if (!st_r.blocked) begin
                        st_nxt.shifter = st_r.work;
                    end
                    st_nxt.state = IDLE;
                    st_nxt.busyLow = 1'b0;
                end else if (st_r.timer == 16'd1) begin
                    st_nxt.timer = 16'd1; // wait for transmission to end
                end
            end
            default: st_nxt.state = IDLE;
        endcase
        // internal clock: exactly twelve pulses, data changes only on falling edge
        if (st_r.txActive) begin
            if (st_r.sclkTimer != 10'd0) begin
                st_nxt.sclkTimer = st_r.sclkTimer - 10'd1;
            end else if (!st_r.sclkLevel) begin
                st_nxt.sclkLevel = 1'b1;
                st_nxt.sclkTimer = 10'(HALF_CYC - 1);
            end else begin
                st_nxt.sclkLevel = 1'b0;
                st_nxt.sclkTimer = 10'(HALF_CYC - 1);
                st_nxt.bitCnt = st_r.bitCnt + 5'd1;
                if (st_r.bitCnt == 5'(RES_BITS - 1)) begin
                    st_nxt.txActive = 1'b0;
                    st_nxt.dataBit = 1'b0;
                end else begin
                    st_nxt.dataBit = st_r.shifter[10 - st_r.bitCnt[3:0]];
                end
            end
        end
        // external clock: rising edge presents next bit, host samples on falling
        if (extMode && extRise && !st_r.txActive) begin
            st_nxt.dataBit = st_r.shifter[11];
            st_nxt.shifter = {st_r.shifter[10:0], 1'b0};
        end
        if (extMode && extFall) begin
            st_nxt.dataBit = st_r.dataBit;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            st_r <= '0;
            st_r.convSync <= 2'h3;
            st_r.csSync <= 2'h3;
            st_r.convPrev <= 1'b1;
            st_r.state <= IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    // outputs released while deselected
    assign serialData = st_r.dataBit;
    assign serialDataOe = pin_enable(st_r.csSync[1]);
    assign busy_n = !st_r.busyLow;
    assign busyOe = pin_enable(st_r.csSync[1]);
    assign serialBitClockOut = st_r.sclkLevel;
    // the pin is only ours when the internal clock is selected
    assign serialBitClockOe = pin_enable(st_r.csSync[1]) && !extMode;
    assign sampleHold = st_r.state != IDLE;

    // busy low whole time internal bits move
    a_busy_frame: assert property (
        @(posedge clk) disable iff (!rst_b)
        st_r.txActive |-> st_r.busyLow
    ) else $error("busy high during transmission");

    // start ignored while converting
    a_start_ignored: assert property (
        @(posedge clk) disable iff (!rst_b)
        (st_r.state == CONVERT && convFall && st_r.timer > 16'd2) |=> st_r.state == CONVERT
    ) else $error("conversion restarted");

    // busy falls the cycle after the synchronised edge
    a_busy_fall: assert property (
        @(posedge clk) disable iff (!rst_b)
        (st_r.state == IDLE && convFall) |=> !busy_n
    ) else $error("busy did not fall");

    // clock idle low outside transmission
    a_clock_idle: assert property (
        @(posedge clk) disable iff (!rst_b)
        !st_r.txActive |-> !st_r.sclkLevel
    ) else $error("clock not idle");

    // chip select high releases every output
    a_enable_off: assert property (
        @(posedge clk) disable iff (!rst_b)
        st_r.csSync[1] |-> !(serialDataOe || busyOe || serialBitClockOe)
    ) else $error("output enabled while deselected");

    // a data bit never moves on the rising edge of the internal clock
    a_bit_stable: assert property (
        @(posedge clk) disable iff (!rst_b)
        (st_r.txActive && $rose(st_r.sclkLevel)) |-> $stable(st_r.dataBit)
    ) else $error("data changed on rising clock");

    // the pulse counter never passes the word length
    a_bit_range: assert property (
        @(posedge clk) disable iff (!rst_b)
        st_r.txActive |-> st_r.bitCnt < 5'(RES_BITS)
    ) else $error("too many clock pulses");

    // a clean update copies the working word into the shifter
    a_update_copy: assert property (
        @(posedge clk) disable iff (!rst_b)
        (st_r.state == SETTLE && st_r.timer == 16'd1 && !st_r.txActive && !st_r.blocked
            && !(extMode && extRise)) |=> st_r.shifter == $past(st_r.work)
    ) else $error("result not copied");

    // a spoiled update leaves the old shifter contents
    a_update_keep: assert property (
        @(posedge clk) disable iff (!rst_b)
        (st_r.state == SETTLE && st_r.timer == 16'd1 && !st_r.txActive && st_r.blocked
            && !(extMode && extRise)) |=> $stable(st_r.shifter)
    ) else $error("spoiled result overwrote shifter");

    // busy returns high on the same edge as the update
    a_busy_rise: assert property (
        @(posedge clk) disable iff (!rst_b)
        (st_r.state == SETTLE && st_r.timer == 16'd1 && !st_r.txActive) |=> busy_n
    ) else $error("busy did not rise");

    // the sample stays held exactly while busy is low
    a_hold_busy: assert property (
        @(posedge clk) disable iff (!rst_b)
        sampleHold == st_r.busyLow
    ) else $error("hold and busy disagree");

    // an internal frame starts with the first edge delay loaded
    a_first_edge: assert property (
        @(posedge clk) disable iff (!rst_b)
        (st_r.state == IDLE && convFall && !extMode)
            |=> st_r.txActive && st_r.sclkTimer == 10'(FIRST_CYC)
    ) else $error("frame not started");
endmodule
`default_nettype wire

// [verification/convert_start_n_host.sv]
// host model: convert start, chip select, external serial clock, serial capture
`default_nettype none
module convert_start_n_host (
    input wire logic clk,
    input wire logic pinClk,
    input wire logic serialData,
    input wire logic busy_n,
    output logic convertStart_n,
    output logic chipSelect_n,
    output logic hostClk
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [11:0] riseWord = 12'h000;
    logic [11:0] fallWord = 12'h000;
    logic pinPrev = 1'b0;
    logic dataPrev = 1'b0;
    int pulses = 0;
    int badFrame = 0;
    initial begin
        convertStart_n = 1'b1;
        chipSelect_n = 1'b0;
        hostClk = 1'b0;
    end
    // pin edges are found on the system clock so data and clock never race
    always @(posedge clk) begin
        if (pinClk && !pinPrev) begin
            riseWord <= {riseWord[10:0], serialData};
            pulses <= pulses + 1;
            if (busy_n !== 1'b0) badFrame <= badFrame + 1;
        end
        // the bit held while the clock was high is the one taken at the fall
        if (!pinClk && pinPrev) fallWord <= {fallWord[10:0], dataPrev};
        pinPrev <= pinClk;
        dataPrev <= serialData;
    end
    // short low pulse, then high well before any next start
    task automatic start_convert_start_n();
        @(negedge clk);
        convertStart_n = 1'b0;
        repeat (20) @(negedge clk); // low for twenty cycles, then released high until the next start
        convertStart_n = 1'b1;
    endtask
    // twelve pulses, 40 ns high in an 80 ns period, started without waiting for busy
    task automatic ext_read();
        repeat (12) begin
            @(negedge clk);
            hostClk = 1'b1;
            repeat (8) @(negedge clk);
            hostClk = 1'b0;
            repeat (7) @(negedge clk);
        end
    endtask
endmodule
`default_nettype wire

// [verification/sar_convert_start_n_serial_tb.sv]
// self-checking bench for conversion control and serial readout
`default_nettype none
module sar_convert_start_n_serial_tb
    import sar_ctl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int LOW = CONVERT_START_N_CYC + READY_CYC;
    localparam logic [11:0] CODES [8] = '{12'h7ff, 12'h000, 12'hfff, 12'h800,
                                          12'h123, 12'habc, 12'h555, 12'haaa};
    logic clk, rst_b, clockSourceSelect, sampleValid;
    logic [11:0] sampleCode;
    wire logic sampleReady, serialBitClockOut, serialBitClockOe, serialData, serialDataOe;
    wire logic busy_n, busyOe, sampleHold, convertStart_n, chipSelect_n, hostClk, pinClk;
    int n_fail = 0;
    int n_tests = 0;
    int lowCnt = 0;
    assign pinClk = serialBitClockOe ? serialBitClockOut : hostClk;
    sar_convert_start_n_serial dut (.clk(clk), .rst_b(rst_b), .convertStart_n(convertStart_n),
        .chipSelect_n(chipSelect_n), .clockSourceSelect(clockSourceSelect),
        .sampleCode(sampleCode), .sampleValid(sampleValid), .sampleReady(sampleReady),
        .serialBitClockOut(serialBitClockOut), .serialBitClockOe(serialBitClockOe),
        .serialBitClockIn(pinClk), .serialData(serialData), .serialDataOe(serialDataOe),
        .busy_n(busy_n), .busyOe(busyOe), .sampleHold(sampleHold));
    convert_start_n_host host (.clk(clk), .pinClk(pinClk), .serialData(serialData), .busy_n(busy_n),
        .convertStart_n(convertStart_n), .chipSelect_n(chipSelect_n), .hostClk(hostClk));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) if (busy_n === 1'b0) lowCnt++;
    task automatic check(input string what, input logic [11:0] exp, input logic [11:0] got);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic push(input logic [11:0] code);
        @(negedge clk);
        sampleCode = code;
        sampleValid = 1'b1;
        @(posedge clk);
        while (sampleReady !== 1'b1) @(posedge clk);
        @(negedge clk);
        sampleValid = 1'b0;
    endtask
    // one conversion; internal selected mode also judges the frame sent meanwhile
    task automatic convert(input bit retrig, input logic [11:0] expWord);
        lowCnt = 0;
        host.pulses = 0;
        host.badFrame = 0;
        host.start_convert_start_n();
        check("busy at start", 12'h000, 12'(busy_n));
        check("hold", 12'h001, 12'(sampleHold));
        check("enables", {9'h0, ~chipSelect_n, ~chipSelect_n, ~chipSelect_n & ~clockSourceSelect},
            {9'h0, busyOe, serialDataOe, serialBitClockOe});
        if (retrig) begin
            repeat (1000) @(negedge clk);
            host.start_convert_start_n();
        end
        for (int i = 0; i < 3000 && busy_n !== 1'b1; i++) @(negedge clk);
        check("busy span", 12'h001, 12'(lowCnt inside {[LOW - 2 : LOW + 2]}));
        if (clockSourceSelect === 1'b0 && chipSelect_n === 1'b0) begin
            check("pulses", 12'h00c, 12'(host.pulses));
            check("rise word", expWord, host.riseWord);
            check("fall word", expWord, host.fallWord);
            check("framing", 12'h000, 12'(host.badFrame));
        end
        repeat (2600) @(negedge clk);
    endtask
    task automatic t_reset();
        check("idle pins", 12'h004, {9'h0, busy_n, serialData, sampleHold});
    endtask
    task automatic t_fill();
        for (int k = 0; k < 8; k++) push(CODES[k]);
        check("fifo full", 12'h000, 12'(sampleReady));
    endtask
    // the first frame is the reset shifter, then each code one conversion late
    task automatic t_internal();
        convert(1'b1, 12'h000);
        for (int k = 1; k < 10; k++) convert(1'b0, k <= 8 ? CODES[k - 1] : 12'h000);
    endtask
    task automatic t_deselect();
        push(12'h7ff);
        host.chipSelect_n = 1'b1;
        convert(1'b0, 12'h000);
        host.chipSelect_n = 1'b0;
    endtask
    task automatic t_external();
        clockSourceSelect = 1'b1;
        repeat (4) @(negedge clk); // let the select pass its synchroniser
        host.ext_read();
        check("ext word", 12'h7ff, host.fallWord);
        push(12'h800);
        convert(1'b0, 12'h000);
        host.ext_read();
        check("ext after", 12'h800, host.fallWord);
    endtask
    initial begin
        rst_b = 1'b0;
        clockSourceSelect = 1'b0;
        sampleValid = 1'b0;
        sampleCode = 12'h000;
        repeat (16) @(negedge clk);
        rst_b = 1'b1;
        repeat (4) @(negedge clk);
        t_reset();
        t_fill();
        t_internal();
        t_deselect();
        t_external();
        final_report();
    end
    // watchdog sized for a dozen conversions at the slowest allowed pace
    initial begin
        repeat (90000) @(posedge clk);
        n_fail++;
        final_report();
    end
endmodule
`default_nettype wire
